// ---- rtl/ibc_top.sv ----
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bit 4 connects level-shift bias to common input
// - bit 3 burn-out polarity, 0 pull-up
// - bits 2:0 burn-out magnitude, 101-111 reserved
// - start low: commands only; high+continuous: free-run
// - reset by power-on, pin, or command
// - power-down by software or pin
// - external clock low selects internal oscillator
// - data-out/ready pin driven only while select low
// - ready also on data pin and pollable
// - results buffered, readable any time
// - bridge drives synchronised, never both active
module ibc_top
    import ibc_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter int CONV_CYC = IBC_CONV_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic reset_pin_n,
    input wire logic power_down_pin_n,
    input wire logic start_pin,
    input wire logic external_clock_input,
    input wire logic chip_select_n,
    input wire logic [DATA_W-1:0] sample_in,
    output logic level_shift_bias_en,
    output logic burnout_polarity,
    output logic [2:0] burnout_magnitude,
    output logic internal_osc_sel,
    output logic serial_out_ready_o,
    output logic serial_out_ready_oe,
    output logic conversion_ready_pin,
    output logic [3:0] bridge_drive
);
    if (DATA_W < 1 || DATA_W > 32 || CONV_CYC < 2) begin : g_bad_params
        $error("ibc_top: unsupported parameters");
    end
    // assertion clock and reset for the checks below
    default clocking ast_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ********************************
    // register state
    // ********************************
    logic [7:0] bias_reg, bias_next;
    logic cont_reg, cont_next;
    logic exc_en_reg, exc_en_next;
    logic exc4_reg, exc4_next;
    logic sw_power_down_pin_reg, sw_power_down_pin_next;
    logic run_reg, run_next;
    logic ready_reg, ready_next;
    logic [IBC_IRQ_W-1:0] irq_st_reg, irq_st_next;
    logic [IBC_IRQ_W-1:0] irq_mask_reg, irq_mask_next;
    logic [DATA_W-1:0] data_reg, data_next;
    logic [31:0] prdata_reg, prdata_next;
    logic phase_reg, phase_next;
    logic [1:0] drive_reg, drive_next;
    logic [31:0] cnt_reg, cnt_next;
    ibc_state_t state_reg, state_next;

    logic wr_en, rd_en, soft_rst, done, any_power_down_pin, start_cmd, stop_cmd;
    logic [IBC_IRQ_W-1:0] irq_set;
    logic addr_ok;

    // accept a write strobe only in the access phase
    assign wr_en = psel && penable && pwrite && clk_en;
    assign rd_en = psel && penable && !pwrite && clk_en;
    assign pready = clk_en;
    assign addr_ok = (paddr == IBC_ADDR_BIAS) || (paddr == IBC_ADDR_CTRL)
        || (paddr == IBC_ADDR_STAT) || (paddr == IBC_ADDR_IRQ)
        || (paddr == IBC_ADDR_MASK) || (paddr == IBC_ADDR_DATA)
        || (paddr == IBC_ADDR_EXC);
    assign pslverr = psel && penable && !addr_ok;

    // command pulses from the control register
    assign soft_rst = wr_en && paddr == IBC_ADDR_CTRL
        && pwdata[IBC_CTL_RESET];
    assign start_cmd = wr_en && paddr == IBC_ADDR_CTRL
        && pwdata[IBC_CTL_START];
    assign stop_cmd = wr_en && paddr == IBC_ADDR_CTRL
        && pwdata[IBC_CTL_STOP];
    assign any_power_down_pin = sw_power_down_pin_reg || !power_down_pin_n;
    assign done = state_reg == IBC_CONV && cnt_reg == 32'(CONV_CYC - 1);

    // ********************************
    // register next values
    // ********************************
    always_comb begin
        bias_next = bias_reg;
        cont_next = cont_reg;
        exc_en_next = exc_en_reg;
        exc4_next = exc4_reg;
        sw_power_down_pin_next = sw_power_down_pin_reg;
        irq_mask_next = irq_mask_reg;
        irq_set = '0;
        irq_set[IBC_IRQ_DONE] = done;
        data_next = done ? sample_in : data_reg;
        ready_next = ready_reg;
        if (done) begin
            ready_next = 1'b1;
        end else if (rd_en && paddr == IBC_ADDR_DATA) begin
            ready_next = 1'b0;
        end
        if (wr_en) begin
            unique case (paddr)
                IBC_ADDR_BIAS: begin
                    bias_next = pwdata[7:0] & IBC_BIAS_MASK;
                    irq_set[IBC_IRQ_BADMAG] =
                        pwdata[IBC_MAG_LSB +: IBC_MAG_W] > IBC_MAG_MAX;
                end
                IBC_ADDR_CTRL: begin
                    cont_next = pwdata[IBC_CTL_CONT];
                    sw_power_down_pin_next = pwdata[IBC_CTL_POWER_DOWN_PIN];
                end
                IBC_ADDR_MASK: irq_mask_next = pwdata[IBC_IRQ_W-1:0];
                IBC_ADDR_EXC: begin
                    exc_en_next = pwdata[IBC_CTL_EXC_EN];
                    exc4_next = pwdata[IBC_CTL_EXC4];
                end
                default: ;
            endcase
        end
        // set wins over write-one-to-clear
        irq_st_next = irq_st_reg;
        if (wr_en && paddr == IBC_ADDR_IRQ) begin
            irq_st_next = irq_st_reg & ~pwdata[IBC_IRQ_W-1:0];
        end
        irq_st_next = irq_st_next | irq_set;
        if (soft_rst) begin
            bias_next = IBC_BIAS_RESET;
            cont_next = 1'b0;
            exc_en_next = 1'b0;
            exc4_next = 1'b0;
            sw_power_down_pin_next = 1'b0;
            irq_mask_next = '0;
            irq_st_next = '0;
            data_next = '0;
            ready_next = 1'b0;
        end
    end

    // ********************************
    // apb read data
    // ********************************
    always_comb begin
        prdata_next = prdata_reg;
        if (psel && !penable && !pwrite) begin
            prdata_next = '0;
            unique case (paddr)
                IBC_ADDR_BIAS: prdata_next[7:0] = bias_reg;
                IBC_ADDR_CTRL: begin
                    prdata_next[IBC_CTL_CONT] = cont_reg;
                    prdata_next[IBC_CTL_POWER_DOWN_PIN] = sw_power_down_pin_reg;
                end
                IBC_ADDR_STAT: begin
                    prdata_next[IBC_ST_READY] = ready_reg;
                    prdata_next[IBC_ST_RUN] =
                        run_reg || (start_pin && cont_reg);
                    prdata_next[IBC_ST_POWER_DOWN_PIN] = any_power_down_pin;
                    prdata_next[IBC_ST_INTCLK] = internal_osc_sel;
                end
                IBC_ADDR_IRQ: prdata_next[IBC_IRQ_W-1:0] = irq_st_reg;
                IBC_ADDR_MASK: prdata_next[IBC_IRQ_W-1:0] = irq_mask_reg;
                IBC_ADDR_DATA: prdata_next[DATA_W-1:0] = data_reg;
                IBC_ADDR_EXC: begin
                    prdata_next[IBC_CTL_EXC_EN] = exc_en_reg;
                    prdata_next[IBC_CTL_EXC4] = exc4_reg;
                end
                default: ;
            endcase
        end
    end

    // ********************************
    // conversion sequencer
    // ********************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        run_next = run_reg;
        phase_next = phase_reg;
        drive_next = drive_reg;
        if (start_cmd) begin
            run_next = 1'b1;
        end
        if (stop_cmd) begin
            run_next = 1'b0;
        end
        unique case (state_reg)
            IBC_IDLE: begin
                drive_next = 2'b00;
                // start pin high in continuous mode free-runs
                if (run_reg || (start_pin && cont_reg)) begin
                    state_next = IBC_CONV;
                    cnt_next = '0;
                    drive_next = phase_reg ? 2'b10 : 2'b01;
                end
            end
            IBC_CONV: begin
                cnt_next = cnt_reg + 32'h1;
                if (done) begin
                    state_next = IBC_GAP;
                    cnt_next = '0;
                    drive_next = 2'b00;
                    phase_next = !phase_reg;
                    if (!cont_reg) begin
                        run_next = 1'b0;
                    end
                end
            end
            IBC_GAP: begin
                cnt_next = cnt_reg + 32'h1;
                if (cnt_reg == 32'(IBC_GAP_CYC - 1)) begin
                    state_next = IBC_IDLE;
                end
            end
            IBC_PDN: begin
                drive_next = 2'b00;
                if (!any_power_down_pin) begin
                    state_next = IBC_IDLE;
                end
            end
        endcase
        if (any_power_down_pin && state_reg != IBC_PDN) begin
            state_next = IBC_PDN;
            drive_next = 2'b00;
            run_next = 1'b0;
        end
        if (soft_rst) begin
            state_next = IBC_IDLE;
            cnt_next = '0;
            run_next = 1'b0;
            phase_next = 1'b0;
            drive_next = 2'b00;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_reg <= IBC_BIAS_RESET;
            cont_reg <= 1'b0;
            exc_en_reg <= 1'b0;
            exc4_reg <= 1'b0;
            sw_power_down_pin_reg <= 1'b0;
            run_reg <= 1'b0;
            ready_reg <= 1'b0;
            irq_st_reg <= '0;
            irq_mask_reg <= '0;
            data_reg <= '0;
            prdata_reg <= '0;
            phase_reg <= 1'b0;
            drive_reg <= 2'b00;
            cnt_reg <= '0;
            state_reg <= IBC_IDLE;
        end else if (!reset_pin_n) begin
            // hardware reset pin, synchronous
            bias_reg <= IBC_BIAS_RESET;
            cont_reg <= 1'b0;
            exc_en_reg <= 1'b0;
            exc4_reg <= 1'b0;
            sw_power_down_pin_reg <= 1'b0;
            run_reg <= 1'b0;
            ready_reg <= 1'b0;
            irq_st_reg <= '0;
            irq_mask_reg <= '0;
            data_reg <= '0;
            prdata_reg <= '0;
            phase_reg <= 1'b0;
            drive_reg <= 2'b00;
            cnt_reg <= '0;
            state_reg <= IBC_IDLE;
        end else if (clk_en) begin
            bias_reg <= bias_next;
            cont_reg <= cont_next;
            exc_en_reg <= exc_en_next;
            exc4_reg <= exc4_next;
            sw_power_down_pin_reg <= sw_power_down_pin_next;
            run_reg <= run_next;
            ready_reg <= ready_next;
            irq_st_reg <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
            data_reg <= data_next;
            prdata_reg <= prdata_next;
            phase_reg <= phase_next;
            drive_reg <= drive_next;
            cnt_reg <= cnt_next;
            state_reg <= state_next;
        end
    end

    // ********************************
    // outputs
    // ********************************
    assign prdata = prdata_reg;
    assign irq = |(irq_st_reg & irq_mask_reg);
    assign level_shift_bias_en = bias_reg[IBC_LEVEL_SHIFT_BIAS_EN_BIT];
    assign burnout_polarity = bias_reg[IBC_POL_BIT];
    // reserved magnitude codes leave the source off
    assign burnout_magnitude =
        (bias_reg[IBC_MAG_LSB +: IBC_MAG_W] > IBC_MAG_MAX) ? 3'h0
        : bias_reg[IBC_MAG_LSB +: IBC_MAG_W];
    assign internal_osc_sel = !external_clock_input;
    assign serial_out_ready_oe = !chip_select_n;
    assign serial_out_ready_o = !ready_reg;
    assign conversion_ready_pin = !ready_reg;
    // two-wire uses pair 0/1, four-wire mirrors onto 2/3
    assign bridge_drive = exc_en_reg
        ? {exc4_reg ? drive_reg : 2'b00, drive_reg} : 4'h0;

    // ********************************
    // checks
    // ********************************
    AST_DRIVE_EXCL: assert property (
        !(drive_reg[0] && drive_reg[1]))
        else $error("bridge drives overlap");
    AST_DRIVE_GAP: assert property (
        (drive_reg != 2'b00) |=> (drive_reg == 2'b00 || $stable(drive_reg)))
        else $error("drive switched without gap");
    AST_LEVEL_SHIFT_BIAS_EN: assert property (
        (wr_en && reset_pin_n && paddr == IBC_ADDR_BIAS)
        |=> level_shift_bias_en == $past(pwdata[IBC_LEVEL_SHIFT_BIAS_EN_BIT]))
        else $error("bias enable not stored");
    AST_POL: assert property (
        (wr_en && reset_pin_n && paddr == IBC_ADDR_BIAS)
        |=> burnout_polarity == $past(pwdata[IBC_POL_BIT]))
        else $error("polarity not stored");
    AST_MAG: assert property (
        burnout_magnitude <= IBC_MAG_MAX)
        else $error("reserved magnitude driven");
    AST_SRST: assert property (
        (soft_rst && reset_pin_n) |=> bias_reg == IBC_BIAS_RESET
        && state_reg == IBC_IDLE)
        else $error("reset command ignored");
    AST_POWER_DOWN_PIN: assert property (
        (sw_power_down_pin_reg && clk_en && reset_pin_n && !soft_rst)
        |=> state_reg == IBC_PDN)
        else $error("power-down not entered");
    AST_OE: assert property (
        chip_select_n |-> !serial_out_ready_oe)
        else $error("pin driven while deselected");
    AST_HOLD: assert property (
        (!done && !soft_rst && reset_pin_n) |=> $stable(data_reg))
        else $error("buffered result changed");
endmodule
`default_nettype wire

// ---- inc/ibc_pkg.sv ----
package ibc_pkg;
    // register byte addresses
    localparam logic [7:0] IBC_ADDR_BIAS = 8'h00;
    localparam logic [7:0] IBC_ADDR_CTRL = 8'h04;
    localparam logic [7:0] IBC_ADDR_STAT = 8'h08;
    localparam logic [7:0] IBC_ADDR_IRQ = 8'h0c;
    localparam logic [7:0] IBC_ADDR_MASK = 8'h10;
    localparam logic [7:0] IBC_ADDR_DATA = 8'h14;
    localparam logic [7:0] IBC_ADDR_EXC = 8'h18;
    // bias register fields
    localparam int IBC_LEVEL_SHIFT_BIAS_EN_BIT = 4;
    localparam int IBC_POL_BIT = 3;
    localparam int IBC_MAG_LSB = 0;
    localparam int IBC_MAG_W = 3;
    localparam logic [7:0] IBC_BIAS_RESET = 8'h00;
    localparam logic [7:0] IBC_BIAS_MASK = 8'h1f;
    localparam logic [2:0] IBC_MAG_MAX = 3'h4;
    // control and excitation register fields
    localparam int IBC_CTL_START = 0;
    localparam int IBC_CTL_STOP = 1;
    localparam int IBC_CTL_RESET = 2;
    localparam int IBC_CTL_POWER_DOWN_PIN = 3;
    localparam int IBC_CTL_CONT = 4;
    localparam int IBC_CTL_EXC_EN = 5;
    localparam int IBC_CTL_EXC4 = 6;
    // status / irq bits
    localparam int IBC_ST_READY = 0;
    localparam int IBC_ST_RUN = 1;
    localparam int IBC_ST_POWER_DOWN_PIN = 2;
    localparam int IBC_ST_INTCLK = 3;
    localparam int IBC_IRQ_W = 2;
    localparam int IBC_IRQ_DONE = 0;
    localparam int IBC_IRQ_BADMAG = 1;
    // conversion timing
    localparam int IBC_CLK_MHZ = 125;
    localparam int IBC_CONV_US = 10;
    localparam int IBC_CONV_CYC = IBC_CONV_US * IBC_CLK_MHZ;
    localparam int IBC_GAP_CYC = 2;
    typedef enum logic [3:0] {
        IBC_IDLE = 4'b0001,
        IBC_CONV = 4'b0010,
        IBC_GAP = 4'b0100,
        IBC_PDN = 4'b1000
    } ibc_state_t;
endpackage

// ---- bench/ibc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host pin model
// ****************************************
module ibc_host #(
    parameter int DATA_W = 24
) (
    input wire logic pclk,
    output logic reset_pin_n,
    output logic power_down_pin_n,
    output logic start_pin,
    output logic external_clock_input,
    output logic chip_select_n,
    output logic [DATA_W-1:0] sample_in
);
    // quiet pins at power-up, conversions held off
    initial begin
        reset_pin_n = 1'b1;
        power_down_pin_n = 1'b1;
        start_pin = 1'b0;
        external_clock_input = 1'b0;
        chip_select_n = 1'b1;
        sample_in = '0;
    end
    // pins: rst_n, pd_n, start, external_clock_input, cs_n; settle one cycle
    task automatic drive(input logic [4:0] p, input logic [DATA_W-1:0] s);
        @(posedge pclk);
        {reset_pin_n, power_down_pin_n, start_pin} <= p[4:2];
        {external_clock_input, chip_select_n} <= p[1:0];
        sample_in <= s;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// ibc_top block testbench
// ****************************************
module tb
    import ibc_pkg::*;
();
    localparam int DW = 24;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic irq, reset_pin_n, power_down_pin_n, start_pin, chip_select_n;
    logic external_clock_input, level_shift_bias_en, burnout_polarity;
    logic [2:0] burnout_magnitude, m;
    logic internal_osc_sel, serial_out_ready_o, serial_out_ready_oe;
    logic conversion_ready_pin, err;
    logic [3:0] bridge_drive, bd_seen;
    logic [DW-1:0] sample_in;
    logic [9:0] pins;
    logic [4:0] b;
    int error_cnt = 0;
    int total_checks = 0;
    int ovl = 0;

    ibc_top #(.DATA_W(DW), .CONV_CYC(8)) ibc_top_inst (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq, .reset_pin_n,
        .power_down_pin_n, .start_pin, .external_clock_input,
        .chip_select_n, .sample_in, .level_shift_bias_en,
        .burnout_polarity, .burnout_magnitude, .internal_osc_sel,
        .serial_out_ready_o, .serial_out_ready_oe,
        .conversion_ready_pin, .bridge_drive
    );
    ibc_host #(.DATA_W(DW)) ibc_host_inst (
        .pclk, .reset_pin_n, .power_down_pin_n, .start_pin,
        .external_clock_input, .chip_select_n, .sample_in
    );

    // pin snapshot: irq level_shift_bias_en pol mag[3] osc sdo sdo_oe ready
    assign pins = {irq, level_shift_bias_en, burnout_polarity,
        burnout_magnitude, internal_osc_sel, serial_out_ready_o,
        serial_out_ready_oe, conversion_ready_pin};

    // half-period clock toggle
    always #4 pclk = ~pclk;

    // bridge drive overlap and coverage watch
    always @(posedge pclk) begin
        if ((bridge_drive[0] && bridge_drive[1]) ||
                (bridge_drive[2] && bridge_drive[3])) begin
            ovl <= ovl + 1;
        end
        bd_seen <= bd_seen | bridge_drive;
    end

    // compare and count
    task automatic chk(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one apb transfer, result in q and err
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // read and compare under a mask
    task automatic rdc(input logic [7:0] a, input logic [31:0] mk,
            input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("reg", q & mk, e);
    endtask
    // pin snapshot compare after outputs settle
    task automatic pchk(input logic [9:0] e);
        @(posedge pclk);
        chk("pins", {22'h0, pins}, {22'h0, e});
    endtask
    // bounded wait for the ready pin to drop
    task automatic wait_rdy();
        int n;
        n = 0;
        while (conversion_ready_pin !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk("ready", {31'h0, conversion_ready_pin}, 32'h0);
    endtask
    // verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #100us;
        error_cnt++;
        end_of_test();
    end

    // test sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        clk_en = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        bd_seen = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        pchk(10'h00d);
        rdc(IBC_ADDR_BIAS, 32'hff, 32'h0);
        rdc(IBC_ADDR_STAT, 32'hf, 32'h8);
        $display("test done: reset values");
        for (int i = 0; i < 32; i++) begin
            b = 5'(i);
            m = (b[2:0] > IBC_MAG_MAX) ? 3'h0 : b[2:0];
            apb(1'b1, IBC_ADDR_BIAS, {27'h7, b});
            rdc(IBC_ADDR_BIAS, (m == b[2:0]) ? 32'hff : 32'hf8,
                {27'h0, b[4:3], m});
            pchk({1'b0, b[4:3], m, 4'hd});
        end
        apb(1'b1, IBC_ADDR_BIAS, 32'h0);
        rdc(IBC_ADDR_IRQ, 32'h3, 32'h2);
        apb(1'b1, IBC_ADDR_MASK, 32'h3);
        pchk(10'h20d);
        apb(1'b1, IBC_ADDR_IRQ, 32'h2);
        pchk(10'h00d);
        $display("test done: bias fields and irq");
        ibc_host_inst.drive(5'h18, 24'h5a3c91);
        apb(1'b1, IBC_ADDR_CTRL, 32'h1);
        wait_rdy();
        pchk(10'h20a);
        rdc(IBC_ADDR_STAT, 32'hf, 32'h9);
        repeat (30) @(posedge pclk);
        rdc(IBC_ADDR_DATA, 32'hffffffff, 32'h5a3c91);
        pchk(10'h20f);
        ibc_host_inst.drive(5'h1b, 24'h5a3c91);
        pchk(10'h205);
        rdc(IBC_ADDR_STAT, 32'h8, 32'h0);
        apb(1'b1, IBC_ADDR_IRQ, 32'h1);
        $display("test done: command conversion");
        apb(1'b1, IBC_ADDR_EXC, 32'h60);
        apb(1'b1, IBC_ADDR_CTRL, 32'h10);
        ibc_host_inst.drive(5'h1c, 24'h123456);
        wait_rdy();
        rdc(IBC_ADDR_DATA, 32'hffffffff, 32'h123456);
        @(posedge pclk);
        wait_rdy();
        rdc(IBC_ADDR_STAT, 32'h3, 32'h3);
        ibc_host_inst.drive(5'h18, 24'h123456);
        apb(1'b1, IBC_ADDR_CTRL, 32'h2);
        rdc(IBC_ADDR_STAT, 32'h2, 32'h0);
        chk("overlap", 32'(ovl), 32'h0);
        chk("drives", {28'h0, bd_seen}, 32'hf);
        $display("test done: free run and excitation");
        apb(1'b1, IBC_ADDR_CTRL, 32'h8);
        rdc(IBC_ADDR_STAT, 32'h4, 32'h4);
        apb(1'b1, IBC_ADDR_CTRL, 32'h0);
        rdc(IBC_ADDR_STAT, 32'h4, 32'h0);
        ibc_host_inst.drive(5'h10, 24'h0);
        rdc(IBC_ADDR_STAT, 32'h4, 32'h4);
        ibc_host_inst.drive(5'h18, 24'h0);
        $display("test done: power down");
        apb(1'b1, IBC_ADDR_BIAS, 32'h1f);
        apb(1'b1, IBC_ADDR_CTRL, 32'h4);
        rdc(IBC_ADDR_BIAS, 32'hff, 32'h0);
        apb(1'b1, IBC_ADDR_BIAS, 32'h1f);
        ibc_host_inst.drive(5'h08, 24'h0);
        ibc_host_inst.drive(5'h18, 24'h0);
        rdc(IBC_ADDR_BIAS, 32'hff, 32'h0);
        $display("test done: resets");
        apb(1'b0, 8'h1c, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        chk("unmapped", q, 32'h0);
        $display("test done: unmapped");
        end_of_test();
    end
endmodule
`default_nettype wire
